// *** hw/pmc_pkg.sv ***
// Constants and types shared by the power mode controller files.
// Assumes a 50 MHz always-on clock; times are given in ns.
package pmc_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int SPIKE_FILTER_NS = 4000;
   localparam int SPIKE_FILTER_CYC = SPIKE_FILTER_NS / CLK_PERIOD_NS;
   localparam int POR_DELAY_NS = 8000000;
   localparam int POR_DELAY_CYC = POR_DELAY_NS / CLK_PERIOD_NS;
   localparam int STARTUP_WD_NS = 64000000;
   localparam int STARTUP_WD_CYC = STARTUP_WD_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 24;
   localparam int FILT_W = 8;

   // ****************************************
   // Counts, codes and reset values
   // ****************************************
   localparam logic [1:0] STARTUP_MAX_MISSES = 2'h3;
   // Aux voltage code: 0 = 1.8 V up to AUX_VSEL_MAX = 3.3 V
   localparam logic [2:0] AUX_VSEL_MAX = 3'h6;
   localparam logic [2:0] AUX_VSEL_RST = 3'h6;

   typedef enum logic [4:0] {
      PMC_POWERUP = 5'h01,
      PMC_NORMAL = 5'h02,
      PMC_RXONLY = 5'h04,
      PMC_STANDBY = 5'h08,
      PMC_SLEEP = 5'h10
   } pmc_mode_t;

   typedef enum logic [1:0] {
      PMC_CMD_NORMAL = 2'h0,
      PMC_CMD_RXONLY = 2'h1,
      PMC_CMD_STANDBY = 2'h2,
      PMC_CMD_SLEEP = 2'h3
   } pmc_cmd_t;

   typedef struct packed {
      logic buck;
      logic main_io_regulator;
      logic aux_regulator_a;
      logic aux_regulator_b;
      logic bus_tx;
      logic bus_rx;
      logic lp_wake_rx;
      logic local_wake;
      logic window_watchdog;
      logic overtemp_monitor;
   } pmc_enables_t;

   typedef struct packed {
      logic temp_warn;
      logic temp_shut;
      logic temp_below_recv;
      logic bus_wake;
      logic local_wake;
      logic battery_uv;
   } pmc_sense_t;

   typedef struct packed {
      logic buck_on_in_sleep;
      logic aux_on_in_standby;
      logic aux_off_in_active;
   } pmc_config_t;

endpackage

// *** hw/pmc_pin_filter.sv ***
// Two-stage synchroniser followed by a stability filter for one pin.
// Assumes an asynchronous pin; output changes after CYCLES stable cycles.
`timescale 1ns/100ps
module pmc_pin_filter
   import pmc_pkg::*;
#(
   parameter int CYCLES = 1
)
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic pin,
   output logic level
);

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic level;
      logic [FILT_W-1:0] cnt;
   } pmc_filt_state_t;

   pmc_filt_state_t s;
   pmc_filt_state_t next_s;

   always_comb
   begin
      next_s = s;
      next_s.sync1 = pin;
      next_s.sync2 = s.sync1;
      if (s.sync2 == s.level)
      begin
         next_s.cnt = '0;
      end
      else if (s.cnt == FILT_W'(CYCLES - 1))
      begin
         next_s.level = s.sync2;
         next_s.cnt = '0;
      end
      else
      begin
         next_s.cnt = s.cnt + FILT_W'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign level = s.level;

endmodule

// *** hw/pmc_power_mode_controller.sv ***
// Power mode controller: mode sequencing and rail/transceiver enables.
// Assumes host commands, config bits and acks come from same-clock logic;
// sense pins and the regulator undervoltage pin are asynchronous.
//
// Notes on behaviour
// - After power-up completes, the controller settles in standby.
// - Four operating modes plus a separate power-up state.
// - Over-temperature in normal disables transmit; mode stays normal.
// - Normal enables buck, main regulator, transceiver and watchdog; aux regulators per config.
// - Receive-only: transmitter off; receiver, regulators, temp monitor on.
// - Standby: transceiver off; wake receiver, main regulator, monitor on.
// - Standby aux regulators default off; host command switches them.
// - Standby leaves for normal, receive-only only by command; for sleep also on shutdown.
// - Sleep entered by host command, shutdown over-temperature or third missed startup trigger.
// - Sleep turns off rails, transceiver, reset, watchdog; bus recessive.
// - Sleep exits only on bus wake or local wake pin.
// - After thermal sleep, wake needs recovery temperature and wake event.
// - Config keeps buck on in sleep, aux regulators on in standby.
// - Active modes run aux regulators unless config turns them off.
// - Reset released after power-on delay of 8 ms, 4 to 12 ms.
// - Main regulator undervoltage filtered against spikes under 4 us.
// - Battery undervoltage forces transmitter so bus stays recessive.
// - Mode control and temperature monitor stay powered in every mode.
// - Host programs aux voltages, applied within 1.8 V to 3.3 V.
// - Warning sets flag, interrupts, blocks transmit; recovery clears flag and block, interrupts again.
// - Shutdown forces sleep, disables wake receiver until recovery.
// - Missed startup trigger retries reset; three misses give sleep.
// - Main regulator undervoltage outside sleep restarts power-up.
`timescale 1ns/100ps
module pmc_power_mode_controller
   import pmc_pkg::*;
#(
   parameter int POR_DELAY_CYCLES = POR_DELAY_CYC,
   parameter int STARTUP_WD_CYCLES = STARTUP_WD_CYC
)
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire pmc_sense_t sense,
   input wire logic main_io_uv,
   input wire logic cmd_valid,
   input wire pmc_cmd_t cmd_mode,
   input wire logic aux_cmd_valid,
   input wire logic aux_a_on_req,
   input wire logic aux_b_on_req,
   input wire logic [2:0] aux_a_vsel_req,
   input wire logic [2:0] aux_b_vsel_req,
   input wire logic startup_wd_trigger,
   input wire logic int_ack,
   input wire pmc_config_t cfg,
   output pmc_enables_t enables,
   output logic reset_out_n,
   output logic bus_force_recessive,
   output logic overtemp_warning,
   output logic interrupt_out_n,
   output pmc_mode_t mode,
   output logic [2:0] aux_a_vsel,
   output logic [2:0] aux_b_vsel
);

   // ****************************************
   // Input conditioning
   // ****************************************
   pmc_sense_t f;
   logic uv_f;

   genvar gi;
   generate
      for (gi = 0; gi < $bits(pmc_sense_t); gi++)
      begin : g_sense
         pmc_pin_filter #(.CYCLES(1)) u_sync (
            .ref_clk(ref_clk),
            .rst_b(rst_b),
            .pin(sense[gi]),
            .level(f[gi])
         );
      end
   endgenerate

   pmc_pin_filter #(.CYCLES(SPIKE_FILTER_CYC)) u_uv_filter (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .pin(main_io_uv),
      .level(uv_f)
   );

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      pmc_mode_t mode;
      logic [CNT_W-1:0] cnt;
      logic wd_phase;
      logic [1:0] misses;
      logic sleep_ot;
      logic warn;
      logic int_pend;
      logic aux_a_cmd;
      logic aux_b_cmd;
      logic [2:0] vsel_a;
      logic [2:0] vsel_b;
      pmc_enables_t en;
      logic rst_n;
      logic force_rec;
   } pmc_state_t;

   localparam pmc_state_t RESET_STATE = '{
      mode: PMC_POWERUP,
      cnt: '0,
      wd_phase: 1'b0,
      misses: 2'h0,
      sleep_ot: 1'b0,
      warn: 1'b0,
      int_pend: 1'b0,
      aux_a_cmd: 1'b0,
      aux_b_cmd: 1'b0,
      vsel_a: AUX_VSEL_RST,
      vsel_b: AUX_VSEL_RST,
      en: '0,
      rst_n: 1'b0,
      force_rec: 1'b0
   };

   pmc_state_t s;
   pmc_state_t next_s;
   logic wake;
   logic active;

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      next_s = s;
      wake = (f.bus_wake && s.en.lp_wake_rx) || f.local_wake;

      // Ack before events, so an event in the ack cycle is kept
      if (int_ack)
      begin
         next_s.int_pend = 1'b0;
      end
      if (s.mode == PMC_NORMAL && f.temp_warn && !s.warn)
      begin
         next_s.warn = 1'b1;
         next_s.int_pend = 1'b1;
      end
      else if (s.warn && f.temp_below_recv)
      begin
         next_s.warn = 1'b0;
         next_s.int_pend = 1'b1;
      end

      case (s.mode)
         PMC_POWERUP:
         begin
            if (!s.wd_phase)
            begin
               if (uv_f)
               begin
                  next_s.cnt = '0;
               end
               else if (s.cnt == CNT_W'(POR_DELAY_CYCLES - 1))
               begin
                  next_s.wd_phase = 1'b1;
                  next_s.cnt = '0;
               end
               else
               begin
                  next_s.cnt = s.cnt + CNT_W'(1);
               end
            end
            else if (startup_wd_trigger)
            begin
               next_s.mode = PMC_STANDBY;
               next_s.misses = 2'h0;
               next_s.cnt = '0;
            end
            else if (s.cnt == CNT_W'(STARTUP_WD_CYCLES - 1))
            begin
               next_s.cnt = '0;
               next_s.wd_phase = 1'b0;
               next_s.misses = s.misses + 2'h1;
               if (s.misses == STARTUP_MAX_MISSES - 2'h1)
               begin
                  next_s.mode = PMC_SLEEP;
               end
            end
            else
            begin
               next_s.cnt = s.cnt + CNT_W'(1);
            end
         end
         PMC_NORMAL, PMC_RXONLY, PMC_STANDBY:
         begin
            // Here standby leaves only by command, as do active modes; undervoltage and shutdown override below
            if (cmd_valid)
            begin
               case (cmd_mode)
                  PMC_CMD_NORMAL: next_s.mode = PMC_NORMAL;
                  PMC_CMD_RXONLY: next_s.mode = PMC_RXONLY;
                  PMC_CMD_STANDBY: next_s.mode = PMC_STANDBY;
                  PMC_CMD_SLEEP: next_s.mode = PMC_SLEEP;
                  default: next_s.mode = s.mode;
               endcase
            end
            if (aux_cmd_valid && s.mode == PMC_STANDBY)
            begin
               next_s.aux_a_cmd = aux_a_on_req;
               next_s.aux_b_cmd = aux_b_on_req;
            end
            if (aux_cmd_valid)
            begin
               // Out-of-range codes clamp to the top voltage
               next_s.vsel_a = (aux_a_vsel_req > AUX_VSEL_MAX) ?
                  AUX_VSEL_MAX : aux_a_vsel_req;
               next_s.vsel_b = (aux_b_vsel_req > AUX_VSEL_MAX) ?
                  AUX_VSEL_MAX : aux_b_vsel_req;
            end
         end
         PMC_SLEEP:
         begin
            if (wake && (!s.sleep_ot || f.temp_below_recv))
            begin
               next_s.mode = PMC_POWERUP;
               next_s.cnt = '0;
               next_s.wd_phase = 1'b0;
               next_s.misses = 2'h0;
            end
         end
         default:
         begin
            next_s.mode = PMC_POWERUP;
            next_s.cnt = '0;
            next_s.wd_phase = 1'b0;
         end
      endcase

      if (uv_f && s.mode != PMC_SLEEP)
      begin
         next_s.mode = PMC_POWERUP;
         next_s.cnt = '0;
         next_s.wd_phase = 1'b0;
         next_s.misses = 2'h0;
      end
      if (f.temp_shut)
      begin
         next_s.mode = PMC_SLEEP;
         next_s.sleep_ot = 1'b1;
      end
      else if (next_s.mode != PMC_SLEEP)
      begin
         next_s.sleep_ot = 1'b0;
      end
      else if (s.mode != PMC_SLEEP)
      begin
         next_s.sleep_ot = 1'b0;
      end
      if (next_s.mode != PMC_STANDBY)
      begin
         next_s.aux_a_cmd = 1'b0;
         next_s.aux_b_cmd = 1'b0;
      end

      // Enables follow the next mode so they change with it
      active = next_s.mode == PMC_NORMAL || next_s.mode == PMC_RXONLY;
      next_s.en.buck = next_s.mode != PMC_SLEEP ||
         cfg.buck_on_in_sleep;
      next_s.en.main_io_regulator = next_s.mode != PMC_SLEEP;
      next_s.en.aux_regulator_a = (active && !cfg.aux_off_in_active) ||
         (next_s.mode == PMC_STANDBY &&
         (next_s.aux_a_cmd || cfg.aux_on_in_standby));
      next_s.en.aux_regulator_b = (active && !cfg.aux_off_in_active) ||
         (next_s.mode == PMC_STANDBY &&
         (next_s.aux_b_cmd || cfg.aux_on_in_standby));
      next_s.en.bus_tx = next_s.mode == PMC_NORMAL && !next_s.warn &&
         !f.battery_uv;
      next_s.en.bus_rx = active;
      next_s.en.lp_wake_rx = (next_s.mode == PMC_STANDBY ||
         next_s.mode == PMC_SLEEP) &&
         !(next_s.sleep_ot && !f.temp_below_recv);
      next_s.en.local_wake = next_s.mode == PMC_STANDBY ||
         next_s.mode == PMC_SLEEP;
      next_s.en.window_watchdog = active ||
         next_s.mode == PMC_STANDBY;
      // Monitor sits in the always-on domain
      next_s.en.overtemp_monitor = 1'b1;
      next_s.rst_n = active || next_s.mode == PMC_STANDBY ||
         (next_s.mode == PMC_POWERUP && next_s.wd_phase);
      next_s.force_rec = f.battery_uv ||
         next_s.mode == PMC_SLEEP;
   end

   // Always-on state: reset only by the internal power-on reset
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s <= RESET_STATE;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign enables = s.en;
   assign reset_out_n = s.rst_n;
   assign bus_force_recessive = s.force_rec;
   assign overtemp_warning = s.warn;
   assign interrupt_out_n = !s.int_pend;
   assign mode = s.mode;
   assign aux_a_vsel = s.vsel_a;
   assign aux_b_vsel = s.vsel_b;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   a_shut_to_sleep: assert property (f.temp_shut |=>
      s.mode == PMC_SLEEP && !s.en.lp_wake_rx && s.sleep_ot)
      else $error("shutdown did not force sleep");
   a_sleep_off: assert property (s.mode == PMC_SLEEP |->
      !s.en.main_io_regulator && !s.en.bus_tx && !s.en.bus_rx &&
      !s.en.window_watchdog && !s.rst_n && s.force_rec)
      else $error("sleep left a block enabled");
   a_normal_on: assert property (s.mode == PMC_NORMAL |->
      s.en.buck && s.en.main_io_regulator && s.en.bus_rx &&
      s.en.window_watchdog &&
      (s.en.aux_regulator_a == !$past(cfg.aux_off_in_active)))
      else $error("normal enables wrong");
   a_rxonly_tx: assert property (s.mode == PMC_RXONLY |->
      !s.en.bus_tx && s.en.bus_rx && s.en.main_io_regulator)
      else $error("receive-only enables wrong");
   a_standby_on: assert property (s.mode == PMC_STANDBY |->
      !s.en.bus_tx && !s.en.bus_rx && s.en.lp_wake_rx &&
      s.en.main_io_regulator)
      else $error("standby enables wrong");
   a_warn_blocks: assert property (s.warn |-> !s.en.bus_tx)
      else $error("transmit on during warning");
   a_standby_cmd: assert property (s.mode == PMC_STANDBY && !cmd_valid &&
      !uv_f && !f.temp_shut |=> s.mode == PMC_STANDBY)
      else $error("standby left without command");
   a_reset_delay: assert property ($rose(s.rst_n) &&
      s.mode == PMC_POWERUP |->
      $past(s.cnt) == CNT_W'(POR_DELAY_CYCLES - 1))
      else $error("reset released before delay");
   a_uv_restart: assert property (uv_f && s.mode != PMC_SLEEP &&
      !f.temp_shut |=> s.mode == PMC_POWERUP && !s.rst_n)
      else $error("undervoltage did not restart");
   a_ot_hold: assert property (s.mode == PMC_SLEEP && s.sleep_ot &&
      !f.temp_below_recv |=> s.mode == PMC_SLEEP)
      else $error("thermal sleep left too early");

   c_normal: cover property (s.mode == PMC_NORMAL);
   c_warn: cover property ($rose(s.warn) ##[1:1000] $fell(s.warn));
   c_retry_sleep: cover property (s.misses == 2'h2 ##1
      s.mode == PMC_SLEEP);
   c_ot_wake: cover property (s.sleep_ot && s.mode == PMC_SLEEP ##1
      s.mode == PMC_POWERUP);

endmodule

// *** bench/pmc_host_model.sv ***
// Host side model: startup trigger plus mode and aux regulator commands.
// Assumes the controller's clock; drives only on the falling edge.
`timescale 1ns/100ps
module pmc_host_model
   import pmc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_out_n,
   input wire logic skip_trigger,
   output logic startup_wd_trigger,
   output logic cmd_valid,
   output pmc_cmd_t cmd_mode,
   output logic aux_cmd_valid,
   output logic aux_a_on_req,
   output logic aux_b_on_req,
   output logic [2:0] aux_a_vsel_req,
   output logic [2:0] aux_b_vsel_req
);
   int run_cnt = 0;

   initial
   begin
      startup_wd_trigger = 1'h0;
      cmd_valid = 1'h0;
      cmd_mode = PMC_CMD_STANDBY;
      aux_cmd_valid = 1'h0;
      {aux_a_on_req, aux_b_on_req} = 2'h0;
      {aux_a_vsel_req, aux_b_vsel_req} = 6'h0;
   end

   // Early in the window, so a slow answer still lands in time
   always @(negedge ref_clk)
   begin
      run_cnt = (reset_out_n === 1'h1) ? run_cnt + 1 : 0;
      startup_wd_trigger <= (run_cnt == 5) && !skip_trigger;
   end

   task automatic send_cmd(input pmc_cmd_t c);
      @(negedge ref_clk);
      cmd_valid <= 1'h1;
      cmd_mode <= c;
      @(negedge ref_clk);
      cmd_valid <= 1'h0;
      cmd_mode <= pmc_cmd_t'(~c);
   endtask

   task automatic send_aux(input logic a, input logic b,
                           input logic [2:0] va, input logic [2:0] vb);
      @(negedge ref_clk);
      aux_cmd_valid <= 1'h1;
      {aux_a_on_req, aux_b_on_req} <= {a, b};
      {aux_a_vsel_req, aux_b_vsel_req} <= {va, vb};
      @(negedge ref_clk);
      aux_cmd_valid <= 1'h0;
      {aux_a_on_req, aux_b_on_req} <= {~a, ~b};
      {aux_a_vsel_req, aux_b_vsel_req} <= {~va, ~vb};
   endtask
endmodule

// *** bench/tb_top.sv ***
// Testbench for the power mode controller with a host model.
// Assumes POR delay and startup watchdog counts shortened by parameter; 50 MHz clock.
`timescale 1ns/100ps
module tb_top
   import pmc_pkg::*;
;
   logic ref_clk = 1'h0;
   logic rst_b = 1'h0;
   logic main_io_uv = 1'h0;
   logic int_ack = 1'h0;
   logic skip_trigger = 1'h0;
   pmc_sense_t sense = '0;
   pmc_config_t cfg = '0;
   pmc_enables_t enables;
   pmc_mode_t mode;
   pmc_cmd_t cmd_mode;
   logic reset_out_n, bus_force_recessive, overtemp_warning, interrupt_out_n;
   logic startup_wd_trigger, cmd_valid, aux_cmd_valid, aux_a_on_req;
   logic aux_b_on_req;
   logic [2:0] aux_a_vsel, aux_b_vsel, aux_a_vsel_req, aux_b_vsel_req;
   int errors = 0;
   int check_count = 0;

   always #10 ref_clk = ~ref_clk;

   pmc_power_mode_controller #(.POR_DELAY_CYCLES(20), .STARTUP_WD_CYCLES(30))
   u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .sense(sense),
      .main_io_uv(main_io_uv), .cmd_valid(cmd_valid), .cmd_mode(cmd_mode),
      .aux_cmd_valid(aux_cmd_valid), .aux_a_on_req(aux_a_on_req),
      .aux_b_on_req(aux_b_on_req), .aux_a_vsel_req(aux_a_vsel_req),
      .aux_b_vsel_req(aux_b_vsel_req), .startup_wd_trigger(startup_wd_trigger),
      .int_ack(int_ack), .cfg(cfg), .enables(enables),
      .reset_out_n(reset_out_n), .bus_force_recessive(bus_force_recessive),
      .overtemp_warning(overtemp_warning), .interrupt_out_n(interrupt_out_n),
      .mode(mode), .aux_a_vsel(aux_a_vsel), .aux_b_vsel(aux_b_vsel));

   pmc_host_model u_host (.ref_clk(ref_clk), .reset_out_n(reset_out_n),
      .skip_trigger(skip_trigger), .startup_wd_trigger(startup_wd_trigger),
      .cmd_valid(cmd_valid), .cmd_mode(cmd_mode),
      .aux_cmd_valid(aux_cmd_valid), .aux_a_on_req(aux_a_on_req),
      .aux_b_on_req(aux_b_on_req), .aux_a_vsel_req(aux_a_vsel_req),
      .aux_b_vsel_req(aux_b_vsel_req));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Bounded wait; running out ends the run
   task automatic wait_mode(input pmc_mode_t m, input int lim);
      for (int i = 0; i < lim && mode !== m; i++)
         @(negedge ref_clk);
      chk(mode, m);
      if (mode !== m)
         final_report();
   endtask

   function automatic pmc_enables_t exp_en(input pmc_mode_t m,
                                           input logic lp);
      logic a, s;
      a = !cfg.aux_off_in_active;
      s = cfg.aux_on_in_standby;
      case (m)
         PMC_NORMAL: exp_en = {2'h3, a, a, 6'h33};
         PMC_RXONLY: exp_en = {2'h3, a, a, 6'h13};
         PMC_STANDBY: exp_en = {2'h3, s, s, 6'h0F};
         PMC_SLEEP: exp_en = {cfg.buck_on_in_sleep, 5'h0, lp, 1'h1, 2'h1};
         default: exp_en = 10'h301;
      endcase
   endfunction

   task automatic do_reset;
      rst_b = 1'h0;
      cyc(3);
      rst_b = 1'h1;
      cyc(1);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_powerup;
      do_reset();
      chk(mode, PMC_POWERUP);
      chk(enables, exp_en(PMC_POWERUP, 1'h0));
      chk({aux_a_vsel, aux_b_vsel}, {AUX_VSEL_RST, AUX_VSEL_RST});
      chk(interrupt_out_n, 1'h1);
      cyc(15);
      chk(reset_out_n, 1'h0);
      wait_mode(PMC_STANDBY, 20);
      chk(reset_out_n, 1'h1);
      chk(enables, exp_en(PMC_STANDBY, 1'h1));
      u_host.send_aux(1'h1, 1'h0, 3'h7, 3'h0);
      chk({aux_a_vsel, aux_b_vsel}, 6'h30);
      chk({enables.aux_regulator_a, enables.aux_regulator_b}, 2'h2);
   endtask

   task automatic t_modes;
      pmc_cmd_t seq[6] = '{PMC_CMD_NORMAL, PMC_CMD_RXONLY, PMC_CMD_STANDBY,
         PMC_CMD_RXONLY, PMC_CMD_NORMAL, PMC_CMD_STANDBY};
      pmc_mode_t m;
      for (int p = 0; p < 2; p++)
      begin
         cfg = p ? 3'h3 : 3'h0;
         for (int i = 0; i < 6; i++)
         begin
            m = pmc_mode_t'(5'h02 << seq[i]);
            u_host.send_cmd(seq[i]);
            chk(mode, m);
            chk(enables, exp_en(m, 1'h1));
         end
      end
      cfg = 3'h0;
   endtask

   task automatic t_warn;
      u_host.send_cmd(PMC_CMD_NORMAL);
      sense.temp_warn = 1'h1;
      cyc(5);
      chk(mode, PMC_NORMAL);
      chk({enables.bus_tx, overtemp_warning, interrupt_out_n}, 3'h2);
      int_ack = 1'h1;
      cyc(1);
      int_ack = 1'h0;
      cyc(1);
      chk(interrupt_out_n, 1'h1);
      sense.temp_warn = 1'h0;
      sense.temp_below_recv = 1'h1;
      cyc(5);
      chk({enables.bus_tx, overtemp_warning, interrupt_out_n}, 3'h4);
      sense.temp_below_recv = 1'h0;
      int_ack = 1'h1;
      cyc(1);
      int_ack = 1'h0;
      sense.battery_uv = 1'h1;
      cyc(5);
      chk({bus_force_recessive, enables.bus_tx}, 2'h2);
      chk(mode, PMC_NORMAL);
      sense.battery_uv = 1'h0;
   endtask

   task automatic t_shut;
      sense.temp_shut = 1'h1;
      cyc(5);
      chk(mode, PMC_SLEEP);
      chk(enables, exp_en(PMC_SLEEP, 1'h0));
      sense = '0;
      sense.local_wake = 1'h1;
      cyc(8);
      chk(mode, PMC_SLEEP);
      sense.local_wake = 1'h0;
      sense.temp_below_recv = 1'h1;
      cyc(5);
      chk(enables.lp_wake_rx, 1'h1);
      sense.local_wake = 1'h1;
      wait_mode(PMC_POWERUP, 8);
      sense = '0;
      wait_mode(PMC_STANDBY, 40);
   endtask

   task automatic t_sleep_cmd;
      cfg = 3'h4;
      u_host.send_cmd(PMC_CMD_SLEEP);
      chk(mode, PMC_SLEEP);
      chk(enables, exp_en(PMC_SLEEP, 1'h1));
      chk(bus_force_recessive, 1'h1);
      u_host.send_cmd(PMC_CMD_NORMAL);
      chk(mode, PMC_SLEEP);
      sense.bus_wake = 1'h1;
      wait_mode(PMC_POWERUP, 8);
      sense.bus_wake = 1'h0;
      cfg = 3'h0;
      wait_mode(PMC_STANDBY, 40);
   endtask

   task automatic t_uv;
      main_io_uv = 1'h1;
      cyc(50);
      main_io_uv = 1'h0;
      cyc(250);
      chk(mode, PMC_STANDBY);
      main_io_uv = 1'h1;
      cyc(150);
      chk(mode, PMC_STANDBY);
      wait_mode(PMC_POWERUP, 70);
      chk(reset_out_n, 1'h0);
      main_io_uv = 1'h0;
      wait_mode(PMC_STANDBY, 300);
   endtask

   task automatic t_miss;
      skip_trigger = 1'h1;
      do_reset();
      wait_mode(PMC_SLEEP, 250);
      skip_trigger = 1'h0;
      do_reset();
      wait_mode(PMC_STANDBY, 40);
   endtask

   initial
   begin
      t_powerup();
      t_modes();
      t_warn();
      t_shut();
      t_sleep_cmd();
      t_uv();
      t_miss();
      final_report();
   end
endmodule
